// ### rtl/pll_clock_fanout_divider.sv
// Clock fanout divider: reference pick, loop, output dividers, register slave
//
// Functional notes
// - Reference choice 1 picks clock B, 0 picks A
// - Inverted output: base rate, opposite polarity
// - Double rate output aligned, twice base rate
// - Half rate output aligned, half base rate
// - Lock high when locked, low otherwise
// - Low enable asynchronously clears divider registers
// - Enable low tri-states outputs, high drives them
// - Loop enable switches the loop on/off
// - Edge choice low: rising, high: falling
// - Fed-back output matches reference, others scaled
// - Range choice only adds oscillator divide-by-two
// - Lock untrusted with oscillator below 30 MHz
// - Eight clock outputs in four kinds
// - Loop only replicates; logic divides afterwards
`timescale 1ns/1ns
`include "pfd_params.svh"
module pll_clock_fanout_divider #(
  parameter int          PW      = 16,
  parameter int          TOL     = 2,
  parameter logic [15:0] PER_MAX = 16'hffff
) (
  input  wire logic              I_CLOCK,
  input  wire logic              I_SYS_RST,
  input  wire logic              I_CLK_EN,
  input  wire logic              I_REF_CLOCK_A,
  input  wire logic              I_REF_CLOCK_B,
  input  wire logic              I_REF_CHOICE,
  input  wire logic              I_VCO_RANGE_CHOICE,
  input  wire logic              I_LOOP_RETURN,
  input  wire logic              I_FALLING_EDGE_CHOICE,
  input  wire logic              I_LOOP_ENABLE,
  input  wire logic              I_OE_RST_N,
  input  wire pfd_pkg::avs_req_s I_AVS,
  output logic [31:0]            O_AVS_READDATA,
  output logic                   O_AVS_WAITREQUEST,
  output pfd_pkg::clk_outs_s     O_CLK_OUT,
  output logic [7:0]             O_CLK_OE,
  output logic                   O_LOCK,
  output logic                   O_IRQ
);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Divider count to output levels; double, base and half rise together at wrap to 7, inverted falls
  function automatic pfd_pkg::clk_outs_s outs_of(input logic [2:0] c);
    pfd_pkg::clk_outs_s o;
    o.double_rate_output   = c[0];
    o.base_rate_outputs    = {5{c[1]}};
    o.inverted_base_output = ~c[1];
    o.half_rate_output     = c[2];
    return o;
  endfunction

  // Output value held while the enable pin clears the dividers
  localparam pfd_pkg::clk_outs_s CLEARED = outs_of(`PFD_CNT_RST);

  // Register read mux
  function automatic logic [31:0] rd_word(input logic [3:0] a,
                                          input logic [7:0] ctrl,
                                          input logic [31:0] st,
                                          input logic [1:0] ist,
                                          input logic [1:0] msk);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      `PFD_OFS_CTRL:     w[7:0] = ctrl;
      `PFD_OFS_STATUS:   w      = st;
      `PFD_OFS_IRQ_STAT: w[1:0] = ist;
      `PFD_OFS_IRQ_MASK: w[1:0] = msk;
      default:           w      = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ==========================================================
  // Reference and return edges
  // ==========================================================
  logic          ref_sel;     // Selected reference level
  logic          refp_q;      // Previous reference level
  logic          fbp_q;       // Previous return level
  logic          ref_edge;    // Chosen edge of the reference
  logic          fb_rise;     // Rising edge of the return
  logic          osc_tick;    // Oscillator or bypass tick
  logic          loop_lock;   // Lock from the loop
  logic [PW-1:0] period;      // Current oscillator half period
  logic [7:0]    ctrl_q;      // Aligned windows for lock
  logic [7:0]    ctrl_d;      // Next aligned window count

  assign ref_sel  = I_REF_CHOICE ? I_REF_CLOCK_B : I_REF_CLOCK_A;
  // Rising edge when choice low, falling when high
  assign ref_edge = I_CLK_EN & (I_FALLING_EDGE_CHOICE ? (refp_q & ~ref_sel)
                                                      : (~refp_q & ref_sel));
  assign fb_rise  = I_CLK_EN & ~fbp_q & I_LOOP_RETURN;

  // Edge history registers
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      // Start from the pin levels so leaving reset makes no false edge
      refp_q <= ref_sel;
      fbp_q  <= I_LOOP_RETURN;
    end else if (I_CLK_EN) begin
      refp_q <= ref_sel;
      fbp_q  <= I_LOOP_RETURN;
    end
  end

  // ==========================================================
  // Loop
  // ==========================================================
  osc_tracker #(
    .PW      (PW),
    .TOL     (TOL),
    .PER_MAX (PW'(PER_MAX))
  ) u_loop (
    .i_clk       (I_CLOCK),
    .i_rst       (I_SYS_RST),
    .i_ce        (I_CLK_EN),
    .i_loop_on   (I_LOOP_ENABLE),
    .i_ref_edge  (ref_edge),
    .i_fb_rise   (fb_rise),
    .i_lock_runs (ctrl_q),
    .o_osc_tick  (osc_tick),
    .o_lock      (loop_lock),
    .o_period    (period)
  );

  // ==========================================================
  // Range prescaler and output dividers
  // ==========================================================
  logic               pre_q, pre_d;  // Oscillator divide-by-two phase
  logic               div_en;        // Divider advance strobe
  logic [2:0]         cnt_q, cnt_d;  // Divider chain
  pfd_pkg::clk_outs_s out_q, out_d;  // Registered output levels

  // Range high halves ticks; bypass skips the prescaler
  assign div_en = osc_tick & (~I_LOOP_ENABLE | ~I_VCO_RANGE_CHOICE | pre_q);

  // Divider next state
  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    if (I_SYS_RST) begin
      pre_d = 1'b0;
      cnt_d = `PFD_CNT_RST;
    end else if (I_CLK_EN) begin
      // Prescaler toggles only in the oscillator path
      if (osc_tick && I_LOOP_ENABLE && I_VCO_RANGE_CHOICE) begin
        pre_d = ~pre_q;
      end
      // Divide after the loop: x2, base, inverted, half
      if (div_en) begin
        cnt_d = cnt_q - 3'h1;
      end
    end
    out_d = outs_of(cnt_d);
  end

  // Divider registers, cleared at once by the enable pin
  always_ff @(posedge I_CLOCK or negedge I_OE_RST_N) begin
    if (!I_OE_RST_N) begin
      pre_q <= 1'b0;
      cnt_q <= `PFD_CNT_RST;
      out_q <= CLEARED;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign O_CLK_OUT = out_q;
  assign O_CLK_OE  = {8{I_OE_RST_N}};
  assign O_LOCK    = loop_lock;

  // ==========================================================
  // Register slave
  // ==========================================================
  pfd_pkg::bus_state_e st_q, st_d;       // Slave phase
  logic [31:0]         rdata_q, rdata_d; // Read data
  logic [1:0]          mask_q, mask_d;   // Interrupt mask
  logic [1:0]          stat_q, stat_d;   // Sticky interrupt status
  logic [1:0]          clr;              // Write-one-to-clear bits
  logic [1:0]          ev;               // Lock gained and lost
  logic                lkp_q;            // Previous lock
  logic                req;              // Read or write pending
  logic [31:0]         status;           // Live status word

  assign req    = I_AVS.read | I_AVS.write;
  assign ev     = {lkp_q & ~loop_lock, ~lkp_q & loop_lock};
  assign status = {{(24 - PW){1'b0}}, period, 6'h00, I_LOOP_ENABLE, loop_lock};

  // Bus and interrupt next state
  always_comb begin
    st_d    = st_q;
    rdata_d = rdata_q;
    ctrl_d  = ctrl_q;
    mask_d  = mask_q;
    clr     = 2'h0;
    unique case (st_q)
      // Take request, latch read data, hold waitrequest one cycle
      pfd_pkg::BUS_IDLE: begin
        if (req) begin
          st_d    = pfd_pkg::BUS_ANSWER;
          rdata_d = I_AVS.read ? rd_word(I_AVS.address, ctrl_q, status,
                                         stat_q, mask_q) : 32'h0000_0000;
        end
      end
      // Waitrequest low: writes take effect now
      pfd_pkg::BUS_ANSWER: begin
        st_d = pfd_pkg::BUS_IDLE;
        if (I_AVS.write && I_AVS.byteenable[0]) begin
          unique case (I_AVS.address)
            `PFD_OFS_CTRL:     ctrl_d = I_AVS.writedata[7:0];
            `PFD_OFS_IRQ_STAT: clr    = I_AVS.writedata[1:0];
            `PFD_OFS_IRQ_MASK: mask_d = I_AVS.writedata[1:0];
            default:           ctrl_d = ctrl_q;
          endcase
        end
      end
    endcase
    // Set wins over a clear in the same cycle
    stat_d = (stat_q & ~clr) | ev;
  end

  // Bus and interrupt registers
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      st_q    <= pfd_pkg::BUS_IDLE;
      rdata_q <= 32'h0000_0000;
      ctrl_q  <= `PFD_CTRL_RST;
      mask_q  <= `PFD_MASK_RST;
      stat_q  <= 2'h0;
      lkp_q   <= 1'b0;
    end else if (I_CLK_EN) begin
      st_q    <= st_d;
      rdata_q <= rdata_d;
      ctrl_q  <= ctrl_d;
      mask_q  <= mask_d;
      stat_q  <= stat_d;
      lkp_q   <= loop_lock;
    end
  end

  assign O_AVS_READDATA    = rdata_q;
  assign O_AVS_WAITREQUEST = req & (st_q != pfd_pkg::BUS_ANSWER);
  assign O_IRQ             = |(stat_q & mask_q);

  // ==========================================================
  // Checks
  // ==========================================================
  a_ref_route: assert property (
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    (ref_edge && $past(I_CLK_EN) && $stable(I_REF_CHOICE))
    |-> (I_REF_CHOICE ? $changed(I_REF_CLOCK_B) : $changed(I_REF_CLOCK_A)))
    else $error("Edge taken from the wrong reference");
  a_edge_pick: assert property (
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    (ref_edge && $past(I_CLK_EN) && $stable(I_REF_CHOICE))
    |-> (I_FALLING_EDGE_CHOICE ? !ref_sel : ref_sel))
    else $error("Reference edge of wrong polarity");
  a_oe_pins: assert property (
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    O_CLK_OE == {8{I_OE_RST_N}})
    else $error("Output enables disagree with enable pin");
  a_clear_outs: assert property (
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    !I_OE_RST_N |-> (O_CLK_OUT == CLEARED && cnt_q == `PFD_CNT_RST))
    else $error("Dividers not cleared by enable pin");
  a_inv_match: assert property (
    @(posedge I_CLOCK) disable iff (I_SYS_RST || !I_OE_RST_N)
    O_CLK_OUT.inverted_base_output == ~O_CLK_OUT.base_rate_outputs[0])
    else $error("Inverted output not opposite to base");
  a_dbl_align: assert property (
    @(posedge I_CLOCK) disable iff (I_SYS_RST || !I_OE_RST_N)
    $rose(O_CLK_OUT.base_rate_outputs[0]) |-> $rose(O_CLK_OUT.double_rate_output))
    else $error("Double rate output not aligned");
  a_half_align: assert property (
    @(posedge I_CLOCK) disable iff (I_SYS_RST || !I_OE_RST_N)
    $rose(O_CLK_OUT.half_rate_output) |-> $rose(O_CLK_OUT.base_rate_outputs[0]))
    else $error("Half rate output not aligned");
  a_div_source: assert property (
    @(posedge I_CLOCK) disable iff (I_SYS_RST || !I_OE_RST_N)
    ($changed(O_CLK_OUT.double_rate_output) && !$past(I_SYS_RST)) |-> $past(div_en))
    else $error("Output moved without a divider tick");
  a_bypass_drive: assert property (
    @(posedge I_CLOCK) disable iff (I_SYS_RST || !I_OE_RST_N)
    (!I_LOOP_ENABLE && ref_edge) |=> $changed(O_CLK_OUT.double_rate_output))
    else $error("Bypass edge did not advance dividers");
  a_range_half: assert property (
    @(posedge I_CLOCK) disable iff (I_SYS_RST || !I_OE_RST_N)
    (I_LOOP_ENABLE && I_VCO_RANGE_CHOICE && div_en)
    |=> (!pre_q && !(I_LOOP_ENABLE && I_VCO_RANGE_CHOICE && div_en)))
    else $error("Prescaler passed two ticks in a row");
  a_bus_answer: assert property (
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    (req && st_q == pfd_pkg::BUS_IDLE && I_CLK_EN) |=> !O_AVS_WAITREQUEST)
    else $error("Bus answer not after one wait cycle");

endmodule

// ### rtl/pfd_params.svh
// Constants of the clock fanout divider: offsets, fields, resets, timing
`ifndef PFD_PARAMS_SVH
`define PFD_PARAMS_SVH

// ==========================================================
// Timing
// ==========================================================
`define PFD_CLK_MHZ       100
`define PFD_LOCK_MIN_MHZ  30

// ==========================================================
// Register offsets (byte addresses)
// ==========================================================
`define PFD_OFS_CTRL      4'h0
`define PFD_OFS_STATUS    4'h4
`define PFD_OFS_IRQ_STAT  4'h8
`define PFD_OFS_IRQ_MASK  4'hc

// ==========================================================
// Fields and reset values
// ==========================================================
`define PFD_CTRL_RUNS_W   8
`define PFD_CTRL_RST      8'h04
`define PFD_ST_LOCK_BIT   0
`define PFD_ST_LOOP_BIT   1
`define PFD_ST_PER_LSB    8
`define PFD_IRQ_W         2
`define PFD_IRQ_GAIN_BIT  0
`define PFD_IRQ_LOSS_BIT  1
`define PFD_MASK_RST      2'h0
`define PFD_PERIOD_RST    16'h0008
`define PFD_CNT_RST       3'h0

`endif

// ### rtl/pfd_pkg.sv
// Types shared by the clock fanout divider files
package pfd_pkg;

  // ==========================================================
  // Clock output group
  // ==========================================================
  typedef struct packed {
    logic       double_rate_output;
    logic [4:0] base_rate_outputs;
    logic       inverted_base_output;
    logic       half_rate_output;
  } clk_outs_s;

  // ==========================================================
  // Avalon-MM request group
  // ==========================================================
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_s;

  // Bus slave states
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;

endpackage

// ### rtl/osc_tracker.sv
// Digital loop: oscillator tick generator that tracks the loop return
`timescale 1ns/1ns
`include "pfd_params.svh"
module osc_tracker #(
  parameter int            PW      = 16,
  parameter int            TOL     = 2,
  parameter logic [PW-1:0] PER_MAX = '1
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_ce,
  input  wire logic          i_loop_on,
  input  wire logic          i_ref_edge,
  input  wire logic          i_fb_rise,
  input  wire logic [7:0]    i_lock_runs,
  output logic               o_osc_tick,
  output logic               o_lock,
  output logic [PW-1:0]      o_period
);

  // Slowest half period (clocks) at which lock can still be trusted
  localparam int            SLOW_I = `PFD_CLK_MHZ / (2 * `PFD_LOCK_MIN_MHZ);
  localparam logic [PW-1:0] SLOW   = PW'((SLOW_I < 1) ? 1 : SLOW_I);
  localparam logic [PW-1:0] TOL_W  = PW'(TOL);

  logic [PW-1:0] per_q,  per_d;   // Oscillator half period
  logic [PW-1:0] tcnt_q, tcnt_d;  // Clocks into current half period
  logic [PW-1:0] cyc_q,  cyc_d;   // Clocks since reference edge
  logic [PW-1:0] offs_q, offs_d;  // Lag of first return edge
  logic [1:0]    fbn_q,  fbn_d;   // Return edges in window
  logic [7:0]    runs_q, runs_d;  // Aligned windows in a row
  logic          hold_q, hold_d;  // One clock phase delay
  logic          lock_q, lock_d;
  logic          tick;
  logic          aligned;

  // ==========================================================
  // Loop next state
  // ==========================================================
  always_comb begin
    per_d   = per_q;
    tcnt_d  = tcnt_q;
    cyc_d   = (cyc_q == PER_MAX) ? cyc_q : cyc_q + PW'(1);
    offs_d  = offs_q;
    fbn_d   = fbn_q;
    runs_d  = runs_q;
    hold_d  = hold_q;
    tick    = 1'b0;
    aligned = (fbn_q == 2'h1) && (offs_q <= TOL_W);
    // Oscillator or reference bypass
    if (!i_loop_on) begin
      tick   = i_ref_edge;
      tcnt_d = '0;
      hold_d = 1'b0;
    end else if (hold_q) begin
      hold_d = 1'b0;
    end else if (tcnt_q >= per_q - PW'(1)) begin
      tick   = 1'b1;
      tcnt_d = '0;
    end else begin
      tcnt_d = tcnt_q + PW'(1);
    end
    // Count return edges inside the window
    if (i_fb_rise) begin
      if (fbn_q != 2'h3) begin
        fbn_d = fbn_q + 2'h1;
      end
      if (fbn_q == 2'h0) begin
        offs_d = cyc_q;
      end
    end
    // Close the window at each reference edge
    if (i_ref_edge) begin
      cyc_d  = '0;
      offs_d = '0;
      fbn_d  = {1'b0, i_fb_rise};
      // Return slower than reference: speed up
      if (fbn_q == 2'h0 && per_q > PW'(1)) begin
        per_d = per_q - PW'(1);
      // Return faster: slow down, never past the range limit
      end else if (fbn_q[1] && per_q < PER_MAX) begin
        per_d = per_q + PW'(1);
      // Right rate, late edge: slip phase by one clock
      end else if (fbn_q == 2'h1 && offs_q > TOL_W) begin
        hold_d = i_loop_on;
      end
      runs_d = !aligned ? 8'h00 : (runs_q == 8'hff) ? runs_q : runs_q + 8'h01;
    end
    // Lock only with loop on, enough aligned windows, fast oscillator
    // Judged on the next period, so lock never stands beside a slow one
    lock_d = i_loop_on && (runs_q >= i_lock_runs) && (i_lock_runs != 8'h00)
             && (per_d <= SLOW);
  end

  // ==========================================================
  // Loop registers
  // ==========================================================
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      per_q  <= PW'(`PFD_PERIOD_RST);
      tcnt_q <= '0;
      cyc_q  <= '0;
      offs_q <= '0;
      fbn_q  <= 2'h0;
      runs_q <= 8'h00;
      hold_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (i_ce) begin
      per_q  <= per_d;
      tcnt_q <= tcnt_d;
      cyc_q  <= cyc_d;
      offs_q <= offs_d;
      fbn_q  <= fbn_d;
      runs_q <= runs_d;
      hold_q <= hold_d;
      lock_q <= lock_d;
    end
  end

  assign o_osc_tick = tick & i_ce;
  assign o_lock     = lock_q;
  assign o_period   = per_q;

  // ==========================================================
  // Checks
  // ==========================================================
  a_lock_off_loop: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (!i_loop_on && i_ce) |=> !o_lock)
    else $error("Lock shown with loop off");
  a_lock_fast_vco: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_lock |-> (o_period <= SLOW))
    else $error("Lock shown with slow oscillator");
  a_speed_up: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && i_loop_on && i_ref_edge && fbn_q == 2'h0 && per_q > PW'(1))
    |=> (per_q == $past(per_q) - PW'(1)))
    else $error("Period not shortened on missing return");

endmodule

// ### verification/board_clock_source.sv
// Board model: reference clock source and loop return wiring
`timescale 1ns/1ns
module board_clock_source #(
  parameter int HALF = 2
) (
  input  wire logic       i_clk,
  input  wire logic       i_run,
  input  wire logic       i_man_a,
  input  wire logic       i_man_b,
  input  wire logic [7:0] i_pins,
  input  wire logic [7:0] i_oe,
  output logic            o_ref_a,
  output logic            o_ref_b,
  output logic            o_ret
);
  // ==========
  // Free running reference
  // ==========
  int   cnt_q  = 0;    // Cycles in this half period
  logic gen_q  = 1'b0; // Generated reference level
  logic last_q = 1'b0; // Last driven return level

  // Toggle every HALF cycles while running
  always_ff @(posedge i_clk) begin
    if (i_run) begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      gen_q <= (cnt_q == HALF - 1) ? ~gen_q : gen_q;
    end
    if (i_oe[2]) begin
      last_q <= i_pins[2];
    end
  end

  // Manual levels when stopped; rate kept above the output floor
  assign o_ref_a = i_run ? gen_q : i_man_a;
  assign o_ref_b = i_run ? gen_q : i_man_b;

  // Base output 0 is the return; double rate never is
  // Undriven return reads as the inverse of its last level
  assign o_ret = i_oe[2] ? i_pins[2] : ~last_q;
endmodule

// ### verification/tb_pll_clock_fanout_divider.sv
// Testbench of the clock fanout divider: bypass, lock, registers
`timescale 1ns/1ns
module tb_pll_clock_fanout_divider;
  // ==========
  // Signals
  // ==========
  logic clk = 1'b0, rst = 1'b1, choice = 1'b0, edge_sel = 1'b0;
  logic loop_on = 1'b0, oe_n = 1'b1, run = 1'b0, man_a = 1'b0, man_b = 1'b0;
  logic ce = 1'b1, range_sel = 1'b0;
  logic ref_a, ref_b, ret, wreq, lock, irq;
  logic [31:0]        rdata;
  logic [7:0]         oe;
  pfd_pkg::clk_outs_s outs;
  pfd_pkg::avs_req_s  avs = '0;
  int failures = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  pll_clock_fanout_divider dut_u (
    .I_CLOCK(clk), .I_SYS_RST(rst), .I_CLK_EN(ce), .I_REF_CLOCK_A(ref_a),
    .I_REF_CLOCK_B(ref_b), .I_REF_CHOICE(choice), .I_VCO_RANGE_CHOICE(range_sel),
    .I_LOOP_RETURN(ret), .I_FALLING_EDGE_CHOICE(edge_sel), .I_LOOP_ENABLE(loop_on),
    .I_OE_RST_N(oe_n), .I_AVS(avs), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wreq), .O_CLK_OUT(outs), .O_CLK_OE(oe), .O_LOCK(lock),
    .O_IRQ(irq));

  board_clock_source board_u (
    .i_clk(clk), .i_run(run), .i_man_a(man_a), .i_man_b(man_b), .i_pins(outs),
    .i_oe(oe), .o_ref_a(ref_a), .o_ref_b(ref_b), .o_ret(ret));

  // ==========
  // Helpers
  // ==========
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    avs.address <= a;
    avs.write <= wr;
    avs.read <= !wr;
    avs.writedata <= d;
    avs.byteenable <= be;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    chk32("waitrequest", 32'h0, {31'h0, wreq});
    avs.read <= 1'b0;
    avs.write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, 4'hf, q);
  endtask

  // Outputs after k divider ticks from clear (count runs 0,7,6,...)
  function automatic logic [7:0] exp_outs(input int k);
    logic [2:0] c;
    c = 3'(8 - (k % 8));
    return {c[0], {5{c[1]}}, ~c[1], c[2]};
  endfunction

  // ==========
  // Scenarios
  // ==========
  task automatic run_regs;
    logic [31:0] q;
    rd(4'h0, q); chk32("ctrl_reset", 32'h4, q);
    rd(4'h4, q); chk32("status_reset", 32'h800, q);
    rd(4'h8, q); chk32("flags_reset", 32'h0, q);
    rd(4'hc, q); chk32("mask_reset", 32'h0, q);
    bus(1'b1, 4'h0, 32'h55, 4'he, q);
    bus(1'b1, 4'h2, 32'h77, 4'hf, q);
    rd(4'h2, q); chk32("unmapped", 32'h0, q);
    rd(4'h0, q); chk32("ctrl_kept", 32'h4, q);
    wr(4'h0, 32'h9);
    rd(4'h0, q); chk32("ctrl_rw", 32'h9, q);
    wr(4'h0, 32'h4);
  endtask

  // Bypass: unselected input ignored, only the chosen edge ticks
  task automatic run_bypass(input logic b, input logic fall);
    loop_on <= 1'b0;
    choice <= b;
    edge_sel <= fall;
    range_sel <= fall;
    man_a <= fall;
    man_b <= fall;
    tick(4);
    oe_n <= 1'b0;
    tick(2);
    chk8("oe_low", 8'h00, oe);
    chk8("cleared", 8'h02, outs);
    oe_n <= 1'b1;
    tick(2);
    chk8("oe_high", 8'hff, oe);
    for (int k = 1; k <= 8; k++) begin
      if (b) man_a <= ~fall; else man_b <= ~fall;
      tick(4);
      if (b) man_a <= fall; else man_b <= fall;
      tick(4);
      chk8("unselected", exp_outs(k - 1), outs);
      if (b) man_b <= ~fall; else man_a <= ~fall;
      tick(4);
      chk8("active_edge", exp_outs(k), outs);
      if (b) man_b <= fall; else man_a <= fall;
      tick(4);
      chk8("other_edge", exp_outs(k), outs);
    end
  endtask

  // Clock enable low freezes dividers; the held edge is taken on return
  task automatic run_freeze;
    ce <= 1'b0;
    man_b <= 1'b0;
    tick(4);
    chk8("frozen", exp_outs(0), outs);
    ce <= 1'b1;
    tick(4);
    chk8("thawed", exp_outs(1), outs);
    man_b <= 1'b1;
    tick(4);
  endtask

  // Loop locks on base return, raises and clears both flags
  task automatic run_lock;
    logic [31:0] q;
    int n;
    choice <= 1'b0;
    range_sel <= 1'b0;
    edge_sel <= 1'b0;
    loop_on <= 1'b1;
    run <= 1'b1;
    wr(4'hc, 32'h0);
    n = 0;
    while (lock !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    chk8("lock", 8'h01, {7'h0, lock});
    rd(4'h4, q); chk32("status_lock", 32'h103, q);
    rd(4'h8, q); chk32("gain_flag", 32'h1, q);
    chk8("irq_masked", 8'h00, {7'h0, irq});
    wr(4'hc, 32'h3);
    tick(1);
    chk8("irq_on", 8'h01, {7'h0, irq});
    wr(4'h8, 32'h1);
    tick(1);
    chk8("irq_cleared", 8'h00, {7'h0, irq});
    loop_on <= 1'b0;
    tick(3);
    chk8("lock_drop", 8'h00, {7'h0, lock});
    chk8("irq_loss", 8'h01, {7'h0, irq});
    rd(4'h8, q); chk32("loss_flag", 32'h2, q);
    rd(4'h4, q); chk32("loop_bit", 32'h0, q & 32'h3);
    wr(4'h8, 32'h2);
    tick(1);
    chk8("irq_idle", 8'h00, {7'h0, irq});
    run <= 1'b0;
  endtask

  // Loop on with range high: prescaler in the oscillator path
  task automatic run_range;
    logic [31:0] q;
    range_sel <= 1'b1;
    loop_on <= 1'b1;
    run <= 1'b1;
    tick(64);
    rd(4'h4, q); chk32("range_loop", 32'h2, q & 32'h2);
    loop_on <= 1'b0;
    range_sel <= 1'b0;
    run <= 1'b0;
    tick(4);
  endtask

  // ==========
  // Sequence and verdict
  // ==========
  task automatic end_of_test;
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    run_regs();
    run_bypass(1'b0, 1'b0);
    run_bypass(1'b1, 1'b0);
    run_bypass(1'b0, 1'b1);
    run_bypass(1'b1, 1'b1);
    run_freeze();
    run_lock();
    run_range();
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
